// *** verilog/sac_ctrl.sv ***
`timescale 1ns/1ps
`default_nettype none
module sac_ctrl
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic clk_en,
  input wire logic chip_sel_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic cmp_hi,
  output logic [sac_pkg::DATA_W-1:0] trial_code,
  output logic [sac_pkg::DATA_W-1:0] data_out,
  output logic [sac_pkg::DATA_W-1:0] data_oe_n,
  output logic conversion_done_irq_n,
  output logic busy
);
  import sac_pkg::*;

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [2:0] pins_sync;
  logic cs_n_s;
  logic rd_n_s;
  logic wr_n_s;

  sac_pin_sync #(.WIDTH(3)) u_sync
  (
    .clk(clk),
    .arst_n(arst_n),
    .clk_en(clk_en),
    .pin_in({chip_sel_n, rd_n, wr_n}),
    .pin_out(pins_sync)
  );

  assign cs_n_s = pins_sync[2];
  assign rd_n_s = pins_sync[1];
  assign wr_n_s = pins_sync[0];

  // ****************************************
  // State
  // ****************************************
  logic [DIV_W-1:0] div_ff;
  logic [DIV_W-1:0] nxt_div;
  logic start_ff;
  logic nxt_start;
  logic first_shift_stage_flop_ff;
  logic nxt_first_shift_stage_flop;
  logic [STEP_W-1:0] step_ff;
  logic [STEP_W-1:0] nxt_step;
  logic [DATA_W-1:0] sar_ff;
  logic [DATA_W-1:0] nxt_sar;
  logic [DATA_W-1:0] result_ff;
  logic [DATA_W-1:0] nxt_result;
  logic irq_ff;
  logic nxt_irq;
  logic [DIV_W:0] set_cnt_ff;
  logic [DIV_W:0] nxt_set_cnt;
  logic wr_n_d_ff;
  logic irq_d_ff;
  sac_state_t state_ff;
  sac_state_t nxt_state;

  logic tick;
  logic start_req;
  logic wr_fall;
  logic rd_en;
  logic start_clear_gate;
  logic result_transfer_gate;

  assign tick = (div_ff == DIV_LAST);
  // Select and write both low, taken from the synchronised pins
  assign start_req = !cs_n_s && !wr_n_s;
  assign wr_fall = wr_n_d_ff && !wr_n_s;
  assign rd_en = !cs_n_s && !rd_n_s;
  assign start_clear_gate = tick && first_shift_stage_flop_ff && !start_req;
  assign result_transfer_gate = tick && (state_ff == SAC_CONV) && (step_ff == STEP_LAST);

  // ****************************************
  // Next state
  // ****************************************
  always_comb
  begin
    nxt_div = div_ff + 3'h1;
    nxt_start = start_ff;
    nxt_first_shift_stage_flop = first_shift_stage_flop_ff;
    nxt_step = step_ff;
    nxt_sar = sar_ff;
    nxt_result = result_ff;
    nxt_irq = irq_ff;
    nxt_set_cnt = set_cnt_ff;
    nxt_state = state_ff;

    if (start_req)
    begin
      // Held in reset as long as the strobes stay low; aborts any conversion
      nxt_start = 1'b1;
      nxt_step = '0;
      nxt_sar = '0;
      nxt_irq = 1'b0;
      nxt_state = SAC_HOLD;
      if (tick)
      begin
        nxt_first_shift_stage_flop = 1'b1;
      end
    end
    else if (start_ff)
    begin
      if (tick)
      begin
        nxt_first_shift_stage_flop = 1'b1;
      end
      if (start_clear_gate)
      begin
        // Marker enters the shift chain; first trial sets the MSB
        nxt_start = 1'b0;
        nxt_first_shift_stage_flop = 1'b0;
        nxt_step = '0;
        nxt_sar = {1'b1, {(DATA_W-1){1'b0}}};
        nxt_state = SAC_CONV;
      end
    end
    else if (state_ff == SAC_CONV && tick)
    begin
      if (step_ff == STEP_LAST)
      begin
        nxt_result = sar_ff;
        nxt_state = SAC_DONE;
        nxt_set_cnt = (DIV_W+1)'(DIV_RATIO);
      end
      else
      begin
        // Keep or drop the bit under trial, then try the next one
        if (!cmp_hi)
        begin
          nxt_sar[DATA_W-1-step_ff[DIV_W-1:0]] = 1'b0;
        end
        if (step_ff != STEP_LAST - 4'h1)
        begin
          nxt_sar[DATA_W-2-step_ff[DIV_W-1:0]] = 1'b1;
        end
        nxt_step = step_ff + 4'h1;
      end
    end

    if (wr_fall)
    begin
      nxt_sar = '0;
      nxt_step = '0;
    end

    // Interrupt set pulse; set wins over a read clear
    if (set_cnt_ff != '0)
    begin
      nxt_set_cnt = set_cnt_ff - 4'h1;
      nxt_irq = 1'b1;
      if (state_ff == SAC_DONE)
      begin
        nxt_state = SAC_IDLE;
      end
    end
    else if (rd_en)
    begin
      nxt_irq = 1'b0;
    end
    if (start_req)
    begin
      nxt_irq = 1'b0;
      nxt_set_cnt = '0;
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      div_ff <= '0;
      start_ff <= 1'b0;
      first_shift_stage_flop_ff <= 1'b0;
      step_ff <= '0;
      sar_ff <= '0;
      result_ff <= RESULT_RST;
      irq_ff <= 1'b0;
      set_cnt_ff <= '0;
      wr_n_d_ff <= 1'b1;
      irq_d_ff <= 1'b0;
      state_ff <= SAC_IDLE;
    end
    else if (clk_en)
    begin
      div_ff <= nxt_div;
      start_ff <= nxt_start;
      first_shift_stage_flop_ff <= nxt_first_shift_stage_flop;
      step_ff <= nxt_step;
      sar_ff <= nxt_sar;
      result_ff <= nxt_result;
      irq_ff <= nxt_irq;
      set_cnt_ff <= nxt_set_cnt;
      wr_n_d_ff <= wr_n_s;
      irq_d_ff <= irq_ff;
      state_ff <= nxt_state;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign trial_code = sar_ff;
  assign data_out = result_ff;
  assign data_oe_n = rd_en ? '0 : '1;
  assign conversion_done_irq_n = !irq_d_ff;
  assign busy = (state_ff == SAC_HOLD) || (state_ff == SAC_CONV);
endmodule
`default_nettype wire

// *** verilog/sac_pkg.sv ***
package sac_pkg;
  // ****************************************
  // Widths and timing
  // ****************************************
  localparam int unsigned DATA_W = 8;
  localparam int unsigned DIV_RATIO = 8;
  localparam int unsigned DIV_W = 3;
  localparam int unsigned STEP_W = 4;
  localparam int unsigned NUM_STEPS = 8;
  localparam int unsigned CLK_PERIOD_PS = 5000;
  // Free-running interrupt low pulse, in ps
  localparam int unsigned FREE_RUN_PULSE_PS = 300000;
  localparam int unsigned FREE_RUN_PULSE_CYC = (FREE_RUN_PULSE_PS / CLK_PERIOD_PS) > 0 ?
    (FREE_RUN_PULSE_PS / CLK_PERIOD_PS) : 1;
  localparam int unsigned SYNC_STAGES = 3;
  localparam logic [DATA_W-1:0] RESULT_RST = 8'h00;
  localparam logic [DATA_W-1:0] FULL_SCALE = 8'hff;
  localparam logic [DIV_W-1:0] DIV_LAST = 3'h7;
  localparam logic [STEP_W-1:0] STEP_LAST = 4'h8;

  // ****************************************
  // Sequencer states
  // ****************************************
  typedef enum logic [1:0]
  {
    SAC_IDLE = 2'b00,
    SAC_HOLD = 2'b01,
    SAC_CONV = 2'b11,
    SAC_DONE = 2'b10
  } sac_state_t;
endpackage

// *** verilog/sac_pin_sync.sv ***
`timescale 1ns/1ps
`default_nettype none
module sac_pin_sync
#(
  parameter int unsigned WIDTH = 4
)
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic clk_en,
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] pin_out
);
  import sac_pkg::*;

  logic [WIDTH-1:0] s1_ff;
  logic [WIDTH-1:0] s2_ff;
  logic [WIDTH-1:0] s3_ff;
  logic [WIDTH-1:0] out_ff;
  logic [WIDTH-1:0] nxt_out;

  // ****************************************
  // Change accepted once stages two and three agree
  // ****************************************
  genvar g;
  generate
    for (g = 0; g < WIDTH; g = g + 1)
    begin : g_bit
      always_comb
      begin
        nxt_out[g] = (s2_ff[g] == s3_ff[g]) ? s3_ff[g] : out_ff[g];
      end
    end
  endgenerate

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      s1_ff <= '1;
      s2_ff <= '1;
      s3_ff <= '1;
      out_ff <= '1;
    end
    else if (clk_en)
    begin
      s1_ff <= pin_in;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      out_ff <= nxt_out;
    end
  end

  assign pin_out = out_ff;
endmodule
`default_nettype wire

// *** test/sac_cmp_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module sac_cmp_model
(
  input wire logic [7:0] vin,
  input wire logic [7:0] trial_code,
  output logic cmp_hi
);
  // Ideal comparator on the analog side
  assign cmp_hi = (vin >= trial_code);
endmodule
`default_nettype wire

// *** test/sac_ctrl_checker.sv ***
`timescale 1ns/1ps
`default_nettype none
module sac_ctrl_checker
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic chip_sel_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic [7:0] trial_code,
  input wire logic [7:0] data_out,
  input wire logic [7:0] data_oe_n,
  input wire logic conversion_done_irq_n,
  input wire logic busy
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  sequence s_start;
    (!chip_sel_n && !wr_n) [*7];
  endsequence
  sequence s_read;
    (!chip_sel_n && !rd_n) [*8];
  endsequence
  a_oe_float: assert property ((chip_sel_n || rd_n) [*5] |-> data_oe_n == 8'hff)
    else $error("outputs driven without read");
  a_oe_drive: assert property ((!chip_sel_n && !rd_n) [*5] |-> data_oe_n == 8'h00)
    else $error("outputs not driven on read");
  a_hold_reset: assert property (s_start |-> busy && trial_code == 8'h00)
    else $error("not held in reset");
  a_start_irq: assert property (s_start |-> conversion_done_irq_n)
    else $error("start did not clear interrupt");
  a_irq_width: assert property ($fell(conversion_done_irq_n) && wr_n |-> !conversion_done_irq_n [*8])
    else $error("interrupt pulse too short");
  a_latch_irq: assert property ($changed(data_out) |-> ##2 $fell(conversion_done_irq_n))
    else $error("latch not followed by interrupt");
  a_read_clr: assert property (s_read ##0 !$past(conversion_done_irq_n, 12)
    |-> ##[0:6] conversion_done_irq_n)
    else $error("read did not clear interrupt");
  a_free_run: assert property ($fell(conversion_done_irq_n) && !wr_n |-> ##[1:12] conversion_done_irq_n)
    else $error("free run pulse too long");
endmodule
bind sac_ctrl sac_ctrl_checker sac_ctrl_checker_i (.clk(clk), .arst_n(arst_n), .chip_sel_n(chip_sel_n),
  .rd_n(rd_n), .wr_n(wr_n), .trial_code(trial_code), .data_out(data_out), .data_oe_n(data_oe_n),
  .conversion_done_irq_n(conversion_done_irq_n), .busy(busy));
`default_nettype wire

// *** test/tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk = 0;
  logic arst_n = 0;
  logic cs_n = 1;
  logic rd_n = 1;
  logic wr_d = 1;
  logic free = 0;
  logic [7:0] vin = 8'h00;
  logic cmp_hi, irq_n, busy;
  logic [7:0] trial, dout, oe_n;
  wire logic wr_n = wr_d & (irq_n | ~free);
  int bad_count = 0;
  int tests_run = 0;
  int cyc = 0;
  int n;
  int pulses = 0;
  bit low_d = 0;
  initial forever #2.5 clk = ~clk;
  sac_ctrl sac_ctrl_i (.clk(clk), .arst_n(arst_n), .clk_en(1'b1), .chip_sel_n(cs_n), .rd_n(rd_n),
    .wr_n(wr_n), .cmp_hi(cmp_hi), .trial_code(trial), .data_out(dout), .data_oe_n(oe_n),
    .conversion_done_irq_n(irq_n), .busy(busy));
  sac_cmp_model sac_cmp_model_i (.vin(vin), .trial_code(trial), .cmp_hi(cmp_hi));
  function automatic logic [7:0] sar(input logic [7:0] v);
    logic [7:0] t;
    t = 8'h00;
    for (int b = 7; b >= 0; b--)
    begin
      t[b] = 1'b1;
      if (v < t)
        t[b] = 1'b0;
    end
    return t;
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_sim();
    if (bad_count == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
  endtask
  task automatic start(input bit hold);
    cs_n <= 1'b0;
    wr_d <= 1'b0;
    tick(8 + $urandom % 8);
    chk({7'h00, busy}, 8'h01);
    chk(trial, 8'h00);
    wr_d <= 1'b1;
    cs_n <= ~hold;
  endtask
  task automatic conv(input logic [7:0] v, input bit ab, input bit hold);
    vin <= v;
    rd_n <= ~hold;
    start(hold);
    if (ab)
    begin
      tick(40);
      start(hold);
    end
    n = 0;
    while (irq_n && n < 200)
    begin
      tick(1);
      n++;
    end
    chk({7'h00, n >= 64 && n <= 90}, 8'h01);
    chk(dout, sar(v));
    tick(hold ? 4 : 8);
    chk({7'h00, irq_n}, 8'h00);
    cs_n <= 1'b0;
    rd_n <= 1'b0;
    tick(16);
    chk(oe_n, 8'h00);
    chk({7'h00, irq_n}, 8'h01);
    cs_n <= 1'b1;
    rd_n <= 1'b1;
    tick(6);
    chk(oe_n, 8'hff);
  endtask
  always @(posedge clk)
  begin
    cyc++;
    if (cyc >= 8000)
    begin
      bad_count++;
      end_sim();
    end
  end
  initial
  begin
    n = $urandom(32'hbbf0ec43);
    tick(10);
    arst_n <= 1'b1;
    tick(1);
    conv(8'hff, 0, 0);
    conv(8'h00, 1, 0);
    conv(8'h81, 0, 1);
    repeat (6)
      conv(8'($urandom), 1'($urandom), 0);
    free <= 1'b1;
    start(1);
    n = 0;
    repeat (400)
    begin
      @(negedge clk);
      if (!irq_n)
        n++;
      if (!irq_n && !low_d)
        pulses++;
      low_d = !irq_n;
    end
    chk({7'h00, pulses >= 3}, 8'h01);
    chk({7'h00, n < pulses * 8}, 8'h01);
    end_sim();
  end
endmodule
`default_nettype wire
